// [msa_pkg.sv]
// constants, commands and states for the memory-addressing core
// What this block does
// - reset starts fetch at 000H bank 0
// - timer 0 interrupt branches to 008H
// - timer 1 interrupt branches to 00CH
// - current-page table read: bank, PC page, pointer
// - last-page table read forces page bits ones
// - pointer at 07H writable, high latch read-only
// - table reads take two instruction cycles
// - eight banks of 8192 words, 3-bit select
// - bank write acts after two more instructions
// - bank select is write-only
// - sample origin drives bits 16..5, rest zero
// - eight-entry stack, invisible to instructions
// - call/interrupt push PC, returns pop it
// - full stack holds interrupt until a return
// - call on full stack drops oldest entry
// - 256-byte map, RAM 30H-FFH, holes read 00H
// - any RAM or writable-register bit settable or clearable
// - ports 00H/02H go through pointers 01H/03H
// - direct port access reads 00H, writes ignored
// - port-to-port move is unsupported
// - accumulator at 05H carries all moves
// - 8-bit ALU updates the status flags
// - fetch address is bank above 13-bit PC
package msa_pkg;

    localparam int PC_W      = 13;
    localparam int BANK_W    = 3;
    localparam int DATA_W    = 8;
    localparam int ROM_W     = 16;
    localparam int WAVE_W    = 17;
    localparam int ORIGIN_W  = 12;
    localparam int ALIGN_W   = 5;
    localparam int PAGE_W    = 5;
    localparam int STK_DEPTH = 8;
    localparam int STK_PTR_W = 3;
    localparam int STK_CNT_W = 4;
    localparam int GP_WORDS  = 208;

    // instruction cycle is four system clocks
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] PHASE_ONE  = 2'h1;

    // data memory map
    localparam logic [7:0] ADDR_IND0  = 8'h00;
    localparam logic [7:0] ADDR_MP0   = 8'h01;
    localparam logic [7:0] ADDR_IND1  = 8'h02;
    localparam logic [7:0] ADDR_MP1   = 8'h03;
    localparam logic [7:0] ADDR_ACC   = 8'h05;
    localparam logic [7:0] ADDR_TABLE_POINTER  = 8'h07;
    localparam logic [7:0] ADDR_TABLE_HIGH_BYTE  = 8'h08;
    localparam logic [7:0] ADDR_GP_LO = 8'h30;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    localparam logic [7:0] BIT_ONE    = 8'h01;

    // program vectors and reset values
    localparam logic [12:0] VEC_RESET  = 13'h0000;
    localparam logic [12:0] VEC_T0     = 13'h0008;
    localparam logic [12:0] VEC_T1     = 13'h000C;
    localparam logic [12:0] PC_ONE     = 13'h0001;
    localparam logic [12:0] PC_TWO     = 13'h0002;
    localparam logic [2:0]  BANK_RESET = 3'h0;
    localparam logic [15:0] ROM_RESET  = 16'h0000;
    localparam logic [4:0]  LAST_PAGE  = 5'h1F;
    localparam logic [4:0]  WAVE_ALIGN = 5'h00;

    // bank countdown in instruction cycles
    localparam logic [1:0] BANK_IDLE  = 2'h0;
    localparam logic [1:0] BANK_APPLY = 2'h1;
    localparam logic [1:0] BANK_ARM   = 2'h2;

    // status flag positions
    localparam int FLAG_C  = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;

    // decimal adjust constants
    localparam logic [3:0] BCD_MAX_NIB = 4'h9;
    localparam logic [7:0] BCD_MAX     = 8'h99;
    localparam logic [8:0] BCD_LO_ADJ  = 9'h006;
    localparam logic [8:0] BCD_HI_ADJ  = 9'h060;

    typedef enum logic [3:0] {
        CMD_NOP  = 4'h0,
        CMD_JMP  = 4'h1,
        CMD_CALL = 4'h2,
        CMD_RET  = 4'h3,
        CMD_INTERRUPT_EXIT = 4'h4,
        CMD_TRDC = 4'h5,
        CMD_TRDL = 4'h6,
        CMD_LDA  = 4'h7,
        CMD_STA  = 4'h8,
        CMD_LDI  = 4'h9,
        CMD_ALU  = 4'hA,
        CMD_SETB = 4'hB,
        CMD_CLRB = 4'hC,
        CMD_BANK = 4'hD
    } msa_cmd_t;

    typedef enum logic [3:0] {
        ALU_ADD = 4'h0,
        ALU_ADC = 4'h1,
        ALU_SUB = 4'h2,
        ALU_SBC = 4'h3,
        ALU_DAA = 4'h4,
        ALU_AND = 4'h5,
        ALU_OR  = 4'h6,
        ALU_XOR = 4'h7,
        ALU_CPL = 4'h8,
        ALU_RL  = 4'h9,
        ALU_RR  = 4'hA,
        ALU_RLC = 4'hB,
        ALU_RRC = 4'hC,
        ALU_INC = 4'hD,
        ALU_DEC = 4'hE,
        ALU_SZ  = 4'hF
    } msa_alu_t;

    typedef enum logic {
        ST_RUN   = 1'b0,
        ST_TABLE = 1'b1
    } msa_state_t;

endpackage

// [msa_core.sv]
// memory-addressing core: program counter, bank, stack, table read, data map, alu
`timescale 1ns/100ps
module msa_core
    import msa_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_cmd_valid,
    input  wire msa_cmd_t             i_cmd,
    input  wire logic [7:0]           i_cmd_addr,
    input  wire logic [2:0]           i_cmd_bit,
    input  wire logic [7:0]           i_cmd_imm,
    input  wire logic [PC_W-1:0]      i_cmd_target,
    input  wire msa_alu_t             i_alu_op,
    input  wire logic                 i_alu_to_mem,
    input  wire logic                 i_t0_irq,
    input  wire logic                 i_t1_irq,
    input  wire logic [ROM_W-1:0]     i_rom_data,
    input  wire logic [ORIGIN_W-1:0]  i_sample_origin,
    output logic                      o_cmd_ready,
    output logic                      o_instr_tick,
    output logic [ROM_W-1:0]          o_rom_addr,
    output logic [WAVE_W-1:0]         o_wave_addr,
    output logic [PC_W-1:0]           o_pc,
    output logic [DATA_W-1:0]         o_acc,
    output logic [3:0]                o_status,
    output logic                      o_t0_ack,
    output logic                      o_t1_ack,
    output logic                      o_interrupt_exit,
    output logic                      o_stack_full
);

    // state
    logic [1:0]            phase_r;
    msa_state_t            state_r;
    msa_state_t            state_nxt;
    logic [PC_W-1:0]       pc_r;
    logic [PC_W-1:0]       pc_nxt;
    logic [BANK_W-1:0]     bank_r;
    logic [BANK_W-1:0]     bank_nxt;
    logic [BANK_W-1:0]     bank_pend_r;
    logic [1:0]            bank_cnt_r;
    logic [DATA_W-1:0]     acc_r;
    logic [DATA_W-1:0]     mp0_r;
    logic [DATA_W-1:0]     mp1_r;
    logic [DATA_W-1:0]     table_pointer_r;
    logic [DATA_W-1:0]     table_high_byte_r;
    logic [3:0]            status_r;
    logic [ROM_W-1:0]      tbl_addr_r;
    logic [7:0]            tbl_dst_r;
    logic [PC_W-1:0]       stk_r [0:STK_DEPTH-1];
    logic [STK_PTR_W-1:0]  stk_top_r;
    logic [STK_CNT_W-1:0]  stk_cnt_r;
    logic [DATA_W-1:0]     ram_r [0:GP_WORDS-1];
    logic [ROM_W-1:0]      rom_addr_r;
    logic [WAVE_W-1:0]     wave_addr_r;
    logic                  t0_ack_r;
    logic                  t1_ack_r;
    logic                  interrupt_exit_r;

    // map an indirect port onto its pointer
    function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] p0, input logic [7:0] p1);
        if (a == ADDR_IND0) begin
            resolve = p0;
        end else if (a == ADDR_IND1) begin
            resolve = p1;
        end else begin
            resolve = a;
        end
    endfunction

    // {ov, ac, c, result} for one alu operation
    function automatic logic [10:0] alu_calc(input msa_alu_t op, input logic [7:0] a,
                                             input logic [7:0] m, input logic [3:0] st);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] b;
        logic       ci;
        logic       c;
        logic       ac;
        logic       ov;
        s  = 9'h000;
        h  = 5'h00;
        b  = m;
        ci = 1'b0;
        c  = st[FLAG_C];
        ac = st[FLAG_AC];
        ov = st[FLAG_OV];
        case (op)
            ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
                b  = (op == ALU_SUB || op == ALU_SBC) ? ~m : m;
                ci = (op == ALU_SUB) ? 1'b1 : ((op == ALU_ADD) ? 1'b0 : st[FLAG_C]);
                s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
                h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
                c  = s[8];
                ac = h[4];
                ov = (a[7] == b[7]) && (s[7] != a[7]);
            end
            ALU_DAA: begin
                s = {1'b0, a};
                if (a[3:0] > BCD_MAX_NIB || st[FLAG_AC]) begin
                    s = s + BCD_LO_ADJ;
                end
                if (a > BCD_MAX || st[FLAG_C]) begin
                    s = s + BCD_HI_ADJ;
                end
                c = s[8] | st[FLAG_C] | (a > BCD_MAX);
            end
            ALU_AND: s = {1'b0, a & m};
            ALU_OR:  s = {1'b0, a | m};
            ALU_XOR: s = {1'b0, a ^ m};
            ALU_CPL: s = {1'b0, ~m};
            ALU_RL:  s = {1'b0, m[6:0], m[7]};
            ALU_RR:  s = {1'b0, m[0], m[7:1]};
            ALU_RLC: begin
                s = {1'b0, m[6:0], st[FLAG_C]};
                c = m[7];
            end
            ALU_RRC: begin
                s = {1'b0, st[FLAG_C], m[7:1]};
                c = m[0];
            end
            ALU_INC: s = {1'b0, m} + 9'h001;
            ALU_DEC: s = {1'b0, m} - 9'h001;
            default: s = {1'b0, m};
        endcase
        alu_calc = {ov, ac, c, s[7:0]};
    endfunction

    // instruction-cycle divider and slot arbitration
    logic ice;
    logic run;
    logic stack_full;
    logic int_req;
    logic int_take;
    logic cmd_take;
    assign ice        = (phase_r == PHASE_LAST);
    assign run        = (state_r == ST_RUN);
    assign stack_full = (stk_cnt_r == STK_CNT_W'(STK_DEPTH));
    assign int_req    = i_t0_irq | i_t1_irq;
    assign int_take   = ice && run && int_req && !stack_full;
    assign cmd_take   = ice && run && !int_take && i_cmd_valid;

    // operand read through the data map
    logic [7:0] eff_addr;
    logic [7:0] gp_idx;
    logic [7:0] rd_data;
    logic       gp_hit;
    assign eff_addr = resolve(i_cmd_addr, mp0_r, mp1_r);
    assign gp_hit   = (eff_addr >= ADDR_GP_LO);
    assign gp_idx   = eff_addr - ADDR_GP_LO;
    // pointer aimed at a port lands on 00H/02H and reads zero
    assign rd_data  = gp_hit ? ram_r[gp_idx] :
                      (eff_addr == ADDR_MP0)  ? mp0_r :
                      (eff_addr == ADDR_MP1)  ? mp1_r :
                      (eff_addr == ADDR_ACC)  ? acc_r :
                      (eff_addr == ADDR_TABLE_POINTER) ? table_pointer_r :
                      (eff_addr == ADDR_TABLE_HIGH_BYTE) ? table_high_byte_r : ZERO_BYTE;

    // alu result and flags
    logic [10:0] alu_out;
    logic [7:0]  alu_res;
    logic        alu_zero;
    logic        z_upd;
    assign alu_out  = alu_calc(i_alu_op, acc_r, rd_data, status_r);
    assign alu_res  = alu_out[7:0];
    assign alu_zero = (alu_res == ZERO_BYTE);
    assign z_upd    = !(i_alu_op inside {ALU_RL, ALU_RR, ALU_RLC, ALU_RRC, ALU_SZ});

    // table address: bank above current or last page, pointer low
    logic [PAGE_W-1:0] tbl_page;
    logic [ROM_W-1:0]  tbl_addr;
    assign tbl_page = (i_cmd == CMD_TRDL) ? LAST_PAGE : pc_r[PC_W-1:PC_W-PAGE_W];
    assign tbl_addr = {bank_r, tbl_page, table_pointer_r};

    // single data write port; the accumulator is just address 05H
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] bit_mask;
    assign bit_mask = BIT_ONE << i_cmd_bit;
    always_comb begin
        wr_en   = 1'b0;
        wr_addr = eff_addr;
        wr_data = ZERO_BYTE;
        if (cmd_take) begin
            case (i_cmd)
                CMD_LDA: begin
                    wr_en   = 1'b1;
                    wr_addr = ADDR_ACC;
                    wr_data = rd_data;
                end
                CMD_STA: begin
                    wr_en   = 1'b1;
                    wr_data = acc_r;
                end
                CMD_LDI: begin
                    wr_en   = 1'b1;
                    wr_addr = ADDR_ACC;
                    wr_data = i_cmd_imm;
                end
                CMD_ALU: begin
                    wr_en   = (i_alu_op != ALU_SZ);
                    wr_addr = i_alu_to_mem ? eff_addr : ADDR_ACC;
                    wr_data = alu_res;
                end
                CMD_SETB: begin
                    wr_en   = 1'b1;
                    wr_data = rd_data | bit_mask;
                end
                CMD_CLRB: begin
                    wr_en   = 1'b1;
                    wr_data = rd_data & ~bit_mask;
                end
                default: wr_en = 1'b0;
            endcase
        end else if (ice && !run) begin
            wr_en   = 1'b1;
            wr_addr = tbl_dst_r;
            wr_data = i_rom_data[7:0];
        end
    end

    // stack push/pop decode on a wrapping ring
    logic            push;
    logic            pop;
    logic [PC_W-1:0] push_val;
    logic [PC_W-1:0] pop_val;
    logic            is_ret;
    assign is_ret   = (i_cmd == CMD_RET) || (i_cmd == CMD_INTERRUPT_EXIT);
    assign push     = int_take || (cmd_take && i_cmd == CMD_CALL);
    assign pop      = cmd_take && is_ret;
    assign push_val = int_take ? pc_r : pc_r + PC_ONE;
    assign pop_val  = stk_r[stk_top_r - STK_PTR_W'(1)];

    // next program counter and state
    always_comb begin
        pc_nxt    = pc_r;
        state_nxt = state_r;
        if (int_take) begin
            pc_nxt = i_t0_irq ? VEC_T0 : VEC_T1;
        end else if (cmd_take) begin
            case (i_cmd)
                CMD_JMP, CMD_CALL: pc_nxt = i_cmd_target;
                CMD_RET, CMD_INTERRUPT_EXIT: pc_nxt = pop_val;
                CMD_TRDC, CMD_TRDL: begin
                    pc_nxt    = pc_r + PC_ONE;
                    state_nxt = ST_TABLE;
                end
                CMD_ALU: pc_nxt = (i_alu_op == ALU_SZ && alu_zero) ? pc_r + PC_TWO : pc_r + PC_ONE;
                default: pc_nxt = pc_r + PC_ONE;
            endcase
        end else if (ice && !run) begin
            state_nxt = ST_RUN;                           // second cycle ends the read
        end
    end

    // bank takes effect at the end of the second instruction cycle after the write
    assign bank_nxt = (ice && bank_cnt_r == BANK_APPLY) ? bank_pend_r : bank_r;

    // phase divider and sequencing registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_r <= 2'h0;
            state_r <= ST_RUN;
            pc_r    <= VEC_RESET;
        end else begin
            phase_r <= phase_r + PHASE_ONE;
            state_r <= state_nxt;
            pc_r    <= pc_nxt;
        end
    end

    // bank select, write-only from the command port
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bank_r      <= BANK_RESET;
            bank_pend_r <= BANK_RESET;
            bank_cnt_r  <= BANK_IDLE;
        end else begin
            bank_r <= bank_nxt;
            if (cmd_take && i_cmd == CMD_BANK) begin
                bank_pend_r <= i_cmd_imm[BANK_W-1:0];
                bank_cnt_r  <= BANK_ARM;
            end else if (ice && bank_cnt_r != BANK_IDLE) begin
                bank_cnt_r <= bank_cnt_r - BANK_APPLY;
            end
        end
    end

    // stack index and depth; a full push overwrites the oldest slot
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stk_top_r <= '0;
            stk_cnt_r <= '0;
        end else if (push) begin
            stk_top_r <= stk_top_r + STK_PTR_W'(1);
            stk_cnt_r <= stack_full ? stk_cnt_r : stk_cnt_r + STK_CNT_W'(1);
        end else if (pop) begin
            stk_top_r <= stk_top_r - STK_PTR_W'(1);
            stk_cnt_r <= (stk_cnt_r == '0) ? stk_cnt_r : stk_cnt_r - STK_CNT_W'(1);
        end
    end

    // stack storage, reachable only by push and pop
    always_ff @(posedge i_mclk) begin
        if (push) begin
            stk_r[stk_top_r] <= push_val;
        end
    end

    // general-purpose ram
    always_ff @(posedge i_mclk) begin
        if (wr_en && wr_addr >= ADDR_GP_LO) begin
            ram_r[wr_addr - ADDR_GP_LO] <= wr_data;
        end
    end

    // special registers; ports 00H/02H and the high latch ignore writes
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_r  <= ZERO_BYTE;
            mp0_r  <= ZERO_BYTE;
            mp1_r  <= ZERO_BYTE;
            table_pointer_r <= ZERO_BYTE;
        end else if (wr_en) begin
            case (wr_addr)
                ADDR_ACC:  acc_r  <= wr_data;
                ADDR_MP0:  mp0_r  <= wr_data;
                ADDR_MP1:  mp1_r  <= wr_data;
                ADDR_TABLE_POINTER: table_pointer_r <= wr_data;
                default:   acc_r  <= acc_r;
            endcase
        end
    end

    // table read capture: address on take, high byte on completion
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tbl_addr_r <= ROM_RESET;
            tbl_dst_r  <= ZERO_BYTE;
            table_high_byte_r     <= ZERO_BYTE;
        end else if (cmd_take && (i_cmd == CMD_TRDC || i_cmd == CMD_TRDL)) begin
            tbl_addr_r <= tbl_addr;
            tbl_dst_r  <= eff_addr;
        end else if (ice && !run) begin
            table_high_byte_r <= i_rom_data[ROM_W-1:DATA_W];
        end
    end

    // status flags from alu commands
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_r <= 4'h0;
        end else if (cmd_take && i_cmd == CMD_ALU) begin
            status_r[FLAG_C]  <= alu_out[8];
            status_r[FLAG_AC] <= alu_out[9];
            status_r[FLAG_OV] <= alu_out[10];
            status_r[FLAG_Z]  <= z_upd ? alu_zero : status_r[FLAG_Z];
        end
    end

    // registered rom and wavetable addresses, event pulses
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rom_addr_r  <= ROM_RESET;
            wave_addr_r <= '0;
            t0_ack_r    <= 1'b0;
            t1_ack_r    <= 1'b0;
            interrupt_exit_r      <= 1'b0;
        end else begin
            rom_addr_r  <= (state_nxt == ST_TABLE) ? ((state_r == ST_RUN) ? tbl_addr : tbl_addr_r)
                                                   : {bank_nxt, pc_nxt};
            wave_addr_r <= {i_sample_origin, WAVE_ALIGN};
            t0_ack_r    <= int_take && i_t0_irq;
            t1_ack_r    <= int_take && !i_t0_irq;
            interrupt_exit_r      <= cmd_take && i_cmd == CMD_INTERRUPT_EXIT;
        end
    end

    // outputs
    assign o_cmd_ready  = ice && run && !int_take;
    assign o_instr_tick = ice;
    assign o_rom_addr   = rom_addr_r;
    assign o_wave_addr  = wave_addr_r;
    assign o_pc         = pc_r;
    assign o_acc        = acc_r;
    assign o_status     = status_r;
    assign o_t0_ack     = t0_ack_r;
    assign o_t1_ack     = t1_ack_r;
    assign o_interrupt_exit       = interrupt_exit_r;
    assign o_stack_full = stack_full;

endmodule

// [msa_rom_model.sv]
// program and wavetable rom model for the core's fetch and table reads
`timescale 1ns/100ps
module msa_rom_model (
    input  wire logic        i_mclk,
    input  wire logic [15:0] i_addr,
    output logic      [15:0] o_data
);
    // one clock access time, word scrambled from its 16-bit address
    always_ff @(posedge i_mclk) begin
        o_data <= {i_addr[7:0] ^ 8'hA5, i_addr[15:8] ^ 8'h3C};
    end
endmodule

// [msa_core_props.sv]
// assertion checker bound to the memory-addressing core
`timescale 1ns/100ps
module msa_core_props
    import msa_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire logic        i_cmd_valid,
    input wire msa_cmd_t    i_cmd,
    input wire logic [11:0] i_sample_origin,
    input wire logic        o_cmd_ready,
    input wire logic [15:0] o_rom_addr,
    input wire logic [16:0] o_wave_addr,
    input wire logic [12:0] o_pc,
    input wire logic        o_t0_ack,
    input wire logic        o_t1_ack,
    input wire logic        o_stack_full
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // command acceptance and program page helpers
    logic       take;
    logic       call_take;
    logic [4:0] pc_page;
    assign take = o_cmd_ready && i_cmd_valid;
    assign call_take = take && i_cmd == CMD_CALL;
    assign pc_page = o_pc[12:8];
    reset_start_a: assert property ($rose(i_rst_n) |-> o_pc == VEC_RESET && !o_stack_full)
        else $error("fetch or stack not clear after reset");
    t0_vector_a: assert property (o_t0_ack |-> o_pc == VEC_T0)
        else $error("timer 0 entry address wrong");
    t1_vector_a: assert property (o_t1_ack |-> o_pc == VEC_T1)
        else $error("timer 1 entry address wrong");
    full_holds_irq_a: assert property ((o_t0_ack || o_t1_ack) |-> !$past(o_stack_full))
        else $error("interrupt taken with full stack");
    table_page_a: assert property (take && i_cmd == CMD_TRDC |=> o_rom_addr[12:8] == $past(pc_page))
        else $error("current page table address wrong");
    last_page_a: assert property (take && i_cmd == CMD_TRDL |=> o_rom_addr[12:8] == LAST_PAGE)
        else $error("last page table address wrong");
    table_busy_a: assert property (take && (i_cmd == CMD_TRDC || i_cmd == CMD_TRDL) |=> (!o_cmd_ready)[*7])
        else $error("table read shorter than two cycles");
    wave_align_a: assert property ($past(i_rst_n) |-> o_wave_addr == {$past(i_sample_origin), WAVE_ALIGN})
        else $error("wave address not aligned origin");
    push_cause_a: assert property ($rose(o_stack_full) |-> $past(call_take) || o_t0_ack || o_t1_ack)
        else $error("stack filled without a push");
    overflow_keep_a: assert property (o_stack_full && call_take |=> o_stack_full)
        else $error("call on full stack changed depth");
endmodule

bind msa_core msa_core_props u_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_sample_origin(i_sample_origin), .o_cmd_ready(o_cmd_ready), .o_rom_addr(o_rom_addr), .o_wave_addr(o_wave_addr),
    .o_pc(o_pc), .o_t0_ack(o_t0_ack), .o_t1_ack(o_t1_ack), .o_stack_full(o_stack_full));

// [msa_core_bench.sv]
// self-checking bench for the memory-addressing core
`timescale 1ns/100ps
module msa_core_bench
    import msa_pkg::*;
;
    logic        i_mclk, i_rst_n, i_cmd_valid, i_alu_to_mem, i_t0_irq, i_t1_irq;
    msa_cmd_t    i_cmd;
    msa_alu_t    i_alu_op;
    logic [7:0]  i_cmd_addr, i_cmd_imm, o_acc, v, a;
    logic [2:0]  i_cmd_bit, b;
    logic [12:0] i_cmd_target, o_pc;
    logic [15:0] i_rom_data, o_rom_addr, w, w2;
    logic [11:0] i_sample_origin;
    logic [16:0] o_wave_addr;
    logic [3:0]  o_status;
    logic        o_cmd_ready, o_instr_tick, o_t0_ack, o_t1_ack, o_interrupt_exit, o_stack_full;
    int          n_fail, compares, acks;

    msa_core i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .i_cmd_addr(i_cmd_addr), .i_cmd_bit(i_cmd_bit), .i_cmd_imm(i_cmd_imm), .i_cmd_target(i_cmd_target),
        .i_alu_op(i_alu_op), .i_alu_to_mem(i_alu_to_mem), .i_t0_irq(i_t0_irq), .i_t1_irq(i_t1_irq),
        .i_rom_data(i_rom_data), .i_sample_origin(i_sample_origin), .o_cmd_ready(o_cmd_ready),
        .o_instr_tick(o_instr_tick), .o_rom_addr(o_rom_addr), .o_wave_addr(o_wave_addr), .o_pc(o_pc),
        .o_acc(o_acc), .o_status(o_status), .o_t0_ack(o_t0_ack), .o_t1_ack(o_t1_ack), .o_interrupt_exit(o_interrupt_exit),
        .o_stack_full(o_stack_full));
    msa_rom_model i_rom (.i_mclk(i_mclk), .i_addr(o_rom_addr), .o_data(i_rom_data));

    // 125 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    // count acknowledge pulses away from the sampling edge
    always @(negedge i_mclk) if (o_t0_ack === 1'b1 || o_t1_ack === 1'b1) acks++;

    function automatic logic [15:0] rom_word(input logic [15:0] ad);
        return {ad[7:0] ^ 8'hA5, ad[15:8] ^ 8'h3C};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // offer a command and hold it until the edge that takes it
    task automatic op(input msa_cmd_t c, input logic [7:0] ad = 8'h00, input logic [7:0] im = 8'h00,
                      input logic [12:0] tg = 13'h0000);
        int n;
        n = 0;
        @(posedge i_mclk);
        #1;
        i_cmd = c;
        i_cmd_addr = ad;
        i_cmd_imm = im;
        i_cmd_target = tg;
        i_cmd_valid = 1'b1;
        while (o_cmd_ready !== 1'b1 && n < 60) begin
            @(negedge i_mclk);
            n++;
        end
        if (n == 60) n_fail++;
        check(o_instr_tick, 1'b1);
        @(posedge i_mclk);
        #1;
        i_cmd_valid = 1'b0;
    endtask
    task automatic put(input logic [7:0] ad, input logic [7:0] val);
        op(CMD_LDI, 8'h00, val);
        op(CMD_STA, ad);
    endtask
    task automatic ld(input logic [7:0] ad);
        op(CMD_LDA, ad);
        @(posedge i_mclk);
        #1;
    endtask
    task automatic wait_ack(input int want);
        int n;
        n = 0;
        while (acks < want && n < 60) begin
            @(posedge i_mclk);
            n++;
        end
        #1;
    endtask
    task automatic wrap_up;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end

    // main sequence
    initial begin
        {i_rst_n, i_cmd_valid, i_alu_to_mem, i_t0_irq, i_t1_irq} = 5'h00;
        {i_cmd_addr, i_cmd_imm, i_cmd_bit, i_cmd_target} = 32'h0;
        i_cmd = CMD_NOP;
        i_alu_op = ALU_ADD;
        i_sample_origin = 12'h5A5;
        void'($urandom(32'h335f));
        repeat (16) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        check({o_pc, o_rom_addr, o_stack_full}, 30'h0);
        repeat (6) begin
            a = 8'h30 + 8'($urandom_range(207));
            v = 8'($urandom);
            b = 3'($urandom);
            put(a, v);
            i_cmd_bit = b;
            op(CMD_SETB, a);
            i_cmd_bit = b + 3'h1;
            op(CMD_CLRB, a);
            v[b] = 1'b1;
            v[b + 3'h1] = 1'b0;
            ld(a);
            check(o_acc, v);
        end
        ld(8'h10);
        check(o_acc, 8'h00);
        ld(ADDR_IND0);
        check(o_acc, 8'h00);
        put(ADDR_MP0, 8'h40);
        put(ADDR_IND0, 8'h5A);
        put(ADDR_MP1, 8'h41);
        put(ADDR_IND1, 8'hC3);
        ld(8'h40);
        check(o_acc, 8'h5A);
        ld(8'h41);
        check(o_acc, 8'hC3);
        v = 8'($urandom);
        a = 8'($urandom);
        put(8'h50, v);
        op(CMD_LDI, 8'h00, a);
        op(CMD_ALU, 8'h50);
        @(posedge i_mclk);
        #1;
        w = {8'h00, v} + {8'h00, a};
        check({o_status[FLAG_C], o_acc}, w[8:0]);
        op(CMD_JMP, 8'h00, 8'h00, 13'h0A10);
        i_alu_op = ALU_SZ;
        op(CMD_ALU, 8'h10);
        check(o_pc, 13'h0A12);
        put(ADDR_TABLE_POINTER, 8'h77);
        op(CMD_TRDC, 8'h60);
        op(CMD_TRDL, 8'h61);
        w = rom_word({3'h0, 5'h0A, 8'h77});
        w2 = rom_word({3'h0, 5'h1F, 8'h77});
        ld(8'h60);
        check(o_acc, w[7:0]);
        ld(8'h61);
        check(o_acc, w2[7:0]);
        put(ADDR_TABLE_HIGH_BYTE, 8'h11);
        ld(ADDR_TABLE_HIGH_BYTE);
        check(o_acc, w2[15:8]);
        ld(ADDR_TABLE_POINTER);
        check(o_acc, 8'h77);
        op(CMD_BANK, 8'h00, 8'h05);
        op(CMD_NOP);
        check(o_rom_addr[15:13], 3'h0);
        op(CMD_NOP);
        check(o_rom_addr[15:13], 3'h5);
        op(CMD_JMP, 8'h00, 8'h00, 13'h0020);
        for (int k = 1; k <= 9; k++) begin
            op(CMD_CALL, 8'h00, 8'h00, {5'(k), 8'h20});
            check(o_stack_full, k >= 8);
        end
        i_t0_irq = 1'b1;
        repeat (3) op(CMD_NOP);
        check(acks, 0);
        op(CMD_RET);
        check(o_interrupt_exit, 1'b0);
        wait_ack(1);
        i_t0_irq = 1'b0;
        check({acks[3:0], o_rom_addr[15:13]}, {4'h1, 3'h5});
        op(CMD_INTERRUPT_EXIT);
        check(o_interrupt_exit, 1'b1);
        i_t1_irq = 1'b1;
        wait_ack(2);
        i_t1_irq = 1'b0;
        check(acks, 2);
        op(CMD_INTERRUPT_EXIT);
        for (int k = 8; k >= 1; k--) begin
            if (k < 8) op(CMD_RET);
            @(posedge i_mclk);
            #1;
            check(o_pc[12:8], 5'(k));
        end
        repeat (4) begin
            i_sample_origin = 12'($urandom);
            @(posedge i_mclk);
            #1;
            check(o_wave_addr, {i_sample_origin, 5'h00});
        end
        wrap_up();
    end
endmodule
